// >>> dtc_pkg.sv
`default_nettype none
package dtc_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the 8-bit register port
  // ----------------------------------------------------------------
  localparam logic [15:0] DTC_CTRL_ADDR = 16'hFFB6;
  localparam logic [15:0] DTC_STAT_ADDR = 16'hFFB7;

  // ----------------------------------------------------------------
  // Reset and read-back values
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_CTRL_RESET    = 8'h00;
  localparam logic [7:0] DTC_STAT_RESET    = 8'h00;
  localparam logic [7:0] DTC_CTRL_READBACK = 8'hFF;
  localparam logic [7:0] DTC_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] DTC_COUNT_MAX     = 8'hFF;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] DTC_CKS_CASCADE = 3'h0;
  localparam logic [2:0] DTC_CKS_STOP    = 3'h0;
  localparam logic [2:0] DTC_CKS_DIV32   = 3'h4;
  localparam logic [2:0] DTC_CKS_DIV16   = 3'h5;
  localparam logic [2:0] DTC_CKS_DIV4    = 3'h6;
  localparam logic [2:0] DTC_CKS_WDIV4   = 3'h7;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int DTC_HI_LEVEL_BIT   = 7;
  localparam int DTC_LO_LEVEL_BIT   = 3;
  localparam int DTC_HI_OVF_BIT     = 7;
  localparam int DTC_HI_MATCH_BIT   = 6;
  localparam int DTC_LO_OVF_BIT     = 3;
  localparam int DTC_LO_MATCH_BIT   = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       hi_toggle_level;
    logic [2:0] hi_clock_select;
    logic       lo_toggle_level;
    logic [2:0] lo_clock_select;
  } dtc_ctrl_t;

  typedef struct packed {
    logic hi_overflow_flag;
    logic hi_match_flag;
    logic hi_overflow_irq_enable;
    logic hi_clear_on_match;
    logic lo_overflow_flag;
    logic lo_match_flag;
    logic lo_overflow_irq_enable;
    logic lo_clear_on_match;
  } dtc_stat_t;

  typedef struct packed {
    logic div32;
    logic div16;
    logic div4;
    logic wdiv4;
  } dtc_ticks_t;

endpackage
`default_nettype wire

// >>> dtc_timer_ctrl.sv
// Contract
// - High clock select picks cascade (000), prohibited (001-011) or one of four prescaler ticks.
// - Low clock select picks stopped (000), prohibited (001-011) or one of four ticks.
// - Low toggle level bit drives the low toggle pin right after the write.
// - High overflow flag sets when the high counter rolls from FF to 00.
// - High overflow flag clears by reading one then writing zero; never set by software.
// - High match flag sets when high counter equals high compare (in cascade mode, when both halves equal their compares).
// - High match flag clears by reading one then writing zero; never set by software.
// - High overflow interrupt enable gates the high overflow request.
// - In cascade mode clear-on-match high clears the whole 16-bit counter on match.
// - In 8-bit mode clear-on-match high clears the high counter on match.
// - Low overflow flag sets when the low counter rolls from FF to 00.
// - Low overflow flag clears by reading one then writing zero; never set by software.
// - Low match flag sets when low counter equals low compare, in 8-bit mode only; never in cascade mode.
// - Low match flag clears by reading one then writing zero; never set by software.
// - Low overflow interrupt enable gates the low overflow request.
// - Clear-on-match low clears the low counter on match, else counting continues.
// - Flag positions accept only zero writes; writing one leaves the flag unchanged.
// - Reset zeroes every bit of the flag and clear control register.
// - In cascade mode the high overflow flag sets on 16-bit rollover FFFF to 0000.
// - Each match inverts that channel's toggle pin, starting from its programmed level; a control write in the same cycle loads the level instead.
// - Match is signalled on the counter tick that leaves the matching value.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_ctrl
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Prescaler ticks, one-cycle pulses on this clock
  input  wire dtc_ticks_t  prescale_tick,
  // Counter and compare values
  input  wire logic [7:0]  hi_counter,
  input  wire logic [7:0]  lo_counter,
  input  wire logic [7:0]  hi_compare,
  input  wire logic [7:0]  lo_compare,
  // Counter control
  output logic             cascade_mode,
  output logic             hi_count_tick,
  output logic             lo_count_tick,
  output logic             hi_clear_req,
  output logic             lo_clear_req,
  // Events and requests
  output logic             hi_match_pulse,
  output logic             lo_match_pulse,
  output logic             hi_overflow_pulse,
  output logic             lo_overflow_pulse,
  output logic             hi_overflow_irq,
  output logic             lo_overflow_irq,
  // Toggle pins
  output logic             hi_toggle_pin,
  output logic             lo_toggle_pin
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  dtc_ctrl_t  ctrl_r;
  logic [3:0] cfg_r;
  logic [3:0] flag_r;
  logic [3:0] seen_r;
  logic [3:0] set_ev;
  logic [7:0] rdata_r;
  dtc_stat_t  stat_view;
  dtc_stat_t  wr_view;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       rd_stat;

  assign wr_ctrl = reg_wr_en && (reg_addr == DTC_CTRL_ADDR);
  assign wr_stat = reg_wr_en && (reg_addr == DTC_STAT_ADDR);
  assign rd_stat = reg_rd_en && (reg_addr == DTC_STAT_ADDR);
  assign wr_view = reg_wdata;

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  // Prohibited codes give no tick so a bad setting simply halts the channel
  function automatic logic sel_tick(input logic [2:0] cks, input dtc_ticks_t t);
    logic r;
    r = 1'b0;
    case (cks)
      DTC_CKS_DIV32: r = t.div32;
      DTC_CKS_DIV16: r = t.div16;
      DTC_CKS_DIV4:  r = t.div4;
      DTC_CKS_WDIV4: r = t.wdiv4;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  assign cascade_mode  = (ctrl_r.hi_clock_select == DTC_CKS_CASCADE);
  assign lo_count_tick = sel_tick(ctrl_r.lo_clock_select, prescale_tick);
  assign lo_overflow_pulse = lo_count_tick && (lo_counter == DTC_COUNT_MAX);
  // High half follows low overflow in cascade mode
  assign hi_count_tick = cascade_mode ? lo_overflow_pulse
                                      : sel_tick(ctrl_r.hi_clock_select, prescale_tick);
  assign hi_overflow_pulse = hi_count_tick && (hi_counter == DTC_COUNT_MAX);

  // ----------------------------------------------------------------
  // Compare match, signalled as the counter leaves the matching value
  // ----------------------------------------------------------------
  assign lo_match_pulse = !cascade_mode && lo_count_tick
                          && (lo_counter == lo_compare);
  assign hi_match_pulse = cascade_mode
                          ? (lo_count_tick && ({hi_counter, lo_counter} == {hi_compare, lo_compare}))
                          : (hi_count_tick && (hi_counter == hi_compare));

  // Clear has priority over the tick at the counters
  assign hi_clear_req = hi_match_pulse && cfg_r[2];
  assign lo_clear_req = cascade_mode ? hi_clear_req
                                     : (lo_match_pulse && cfg_r[0]);

  // ----------------------------------------------------------------
  // Clock and level control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= DTC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Toggle pins
  // ----------------------------------------------------------------
  // A level write beats a match in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_toggle_pin <= 1'b0;
      lo_toggle_pin <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      hi_toggle_pin <= reg_wdata[DTC_HI_LEVEL_BIT];
      lo_toggle_pin <= reg_wdata[DTC_LO_LEVEL_BIT];
    end
    else
    begin
      if (hi_match_pulse)
        hi_toggle_pin <= !hi_toggle_pin;
      if (lo_match_pulse)
        lo_toggle_pin <= !lo_toggle_pin;
    end
  end

  // ----------------------------------------------------------------
  // Enables and clear-on-match bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cfg_r <= 4'h0;
    else if (wr_stat)
      cfg_r <= {wr_view.hi_overflow_irq_enable, wr_view.hi_clear_on_match,
                wr_view.lo_overflow_irq_enable, wr_view.lo_clear_on_match};
  end

  // ----------------------------------------------------------------
  // Status flags: 0 hi overflow, 1 hi match, 2 lo overflow, 3 lo match
  // ----------------------------------------------------------------
  assign set_ev = {lo_match_pulse, lo_overflow_pulse, hi_match_pulse, hi_overflow_pulse};

  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_flag
      localparam int POS = (g < 2) ? (DTC_HI_OVF_BIT - g) : (DTC_LO_OVF_BIT + 2 - g);

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          flag_r[g] <= 1'b0;
        else if (set_ev[g])
          flag_r[g] <= 1'b1;
        else if (wr_stat && !reg_wdata[POS] && seen_r[g])
          flag_r[g] <= 1'b0;
      end

      // Any write to the register consumes the read observation
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          seen_r[g] <= 1'b0;
        else if (wr_stat)
          seen_r[g] <= 1'b0;
        else if (rd_stat && flag_r[g])
          seen_r[g] <= 1'b1;
      end
    end
  endgenerate

  assign stat_view = '{hi_overflow_flag:       flag_r[0],
                       hi_match_flag:          flag_r[1],
                       hi_overflow_irq_enable: cfg_r[3],
                       hi_clear_on_match:      cfg_r[2],
                       lo_overflow_flag:       flag_r[2],
                       lo_match_flag:          flag_r[3],
                       lo_overflow_irq_enable: cfg_r[1],
                       lo_clear_on_match:      cfg_r[0]};

  // ----------------------------------------------------------------
  // Read data, held until the next read
  // ----------------------------------------------------------------
  // Control register is write-only and reads back a fixed value
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= DTC_STAT_RESET;
    else if (reg_rd_en)
    begin
      if (reg_addr == DTC_CTRL_ADDR)
        rdata_r <= DTC_CTRL_READBACK;
      else if (reg_addr == DTC_STAT_ADDR)
        rdata_r <= stat_view;
      else
        rdata_r <= DTC_UNMAPPED_READ;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Overflow requests
  // ----------------------------------------------------------------
  assign hi_overflow_irq = flag_r[0] && cfg_r[3];
  assign lo_overflow_irq = flag_r[2] && cfg_r[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_read_lo_match;
    rd_stat && flag_r[3] && !wr_stat;
  endsequence

  sequence s_zero_lo_match;
    wr_stat && !reg_wdata[DTC_LO_MATCH_BIT] && !set_ev[3];
  endsequence

  property p_lo_stopped;
    (ctrl_r.lo_clock_select == DTC_CKS_STOP) |-> !lo_count_tick && !lo_match_pulse;
  endproperty
  a_lo_stopped: assert property (p_lo_stopped) else $error("low channel ticks while stopped");

  property p_hi_div32;
    (ctrl_r.hi_clock_select == DTC_CKS_DIV32) && prescale_tick.div32 |-> hi_count_tick;
  endproperty
  a_hi_div32: assert property (p_hi_div32) else $error("high channel missed div32 tick");

  property p_lo_level_write;
    wr_ctrl |=> lo_toggle_pin == $past(reg_wdata[DTC_LO_LEVEL_BIT]);
  endproperty
  a_lo_level_write: assert property (p_lo_level_write) else $error("low pin ignores level");

  property p_hi_ovf_set;
    hi_overflow_pulse |=> flag_r[0] ##1 (flag_r[0] || $past(wr_stat));
  endproperty
  a_hi_ovf_set: assert property (p_hi_ovf_set) else $error("high overflow flag not set");

  property p_lo_match_clear;
    s_read_lo_match ##1 s_zero_lo_match |=> !flag_r[3];
  endproperty
  a_lo_match_clear: assert property (p_lo_match_clear) else $error("low match not cleared");

  property p_no_sw_set;
    wr_stat && !flag_r[0] && !set_ev[0] |=> !flag_r[0];
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("software set overflow flag");

  property p_clear_needs_read;
    wr_stat && flag_r[1] && !seen_r[1] |=> flag_r[1];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("unread flag cleared");

  property p_set_wins;
    set_ev[1] && wr_stat |=> flag_r[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match lost to clear");

  property p_irq_follows;
    lo_overflow_pulse && cfg_r[1] && !wr_stat |=> lo_overflow_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("low overflow request missing");

  property p_cascade_clear;
    cascade_mode && hi_match_pulse && cfg_r[2] |-> lo_clear_req && hi_clear_req;
  endproperty
  a_cascade_clear: assert property (p_cascade_clear) else $error("16-bit clear incomplete");

  property p_hi_toggle;
    hi_match_pulse && !wr_ctrl |=> hi_toggle_pin != $past(hi_toggle_pin);
  endproperty
  a_hi_toggle: assert property (p_hi_toggle) else $error("high pin did not toggle");

  property p_cascade_ovf;
    cascade_mode && lo_count_tick && (hi_counter == DTC_COUNT_MAX)
      && (lo_counter == DTC_COUNT_MAX) |-> hi_overflow_pulse;
  endproperty
  a_cascade_ovf: assert property (p_cascade_ovf) else $error("16-bit rollover missed");

  property p_lo_match_gap;
    s_read_lo_match ##1 !wr_stat ##1 s_zero_lo_match |=> !flag_r[3];
  endproperty
  a_lo_match_gap: assert property (p_lo_match_gap) else $error("low match kept");

  property p_set_wins_lo;
    set_ev[2] && wr_stat |=> flag_r[2];
  endproperty
  a_set_wins_lo: assert property (p_set_wins_lo) else $error("low overflow lost");

  property p_lo_toggle;
    lo_match_pulse && !wr_ctrl |=> lo_toggle_pin != $past(lo_toggle_pin);
  endproperty
  a_lo_toggle: assert property (p_lo_toggle) else $error("low pin did not toggle");

  property p_hi_match_set;
    hi_match_pulse |=> flag_r[1];
  endproperty
  a_hi_match_set: assert property (p_hi_match_set) else $error("high match not set");

  property p_lo_ovf_set;
    lo_overflow_pulse |=> flag_r[2];
  endproperty
  a_lo_ovf_set: assert property (p_lo_ovf_set) else $error("low overflow not set");

  property p_lo_no_clear;
    !cascade_mode && !cfg_r[0] |-> !lo_clear_req;
  endproperty
  a_lo_no_clear: assert property (p_lo_no_clear) else $error("low clear not enabled");

endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dtc_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clock;
  logic        rst_n;
  logic [15:0] reg_addr;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  dtc_ticks_t  prescale_tick;
  logic [7:0]  hi_counter, lo_counter, hi_compare, lo_compare;
  logic        cascade_mode, hi_count_tick, lo_count_tick, hi_clear_req, lo_clear_req;
  logic        hi_match_pulse, lo_match_pulse, hi_overflow_pulse, lo_overflow_pulse;
  logic        hi_overflow_irq, lo_overflow_irq, hi_toggle_pin, lo_toggle_pin;
  logic [7:0]  v;
  int          mismatches;
  int          num_checks;

  dtc_timer_ctrl u_dut (
    .clock, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata,
    .prescale_tick, .hi_counter, .lo_counter, .hi_compare, .lo_compare,
    .cascade_mode, .hi_count_tick, .lo_count_tick, .hi_clear_req, .lo_clear_req,
    .hi_match_pulse, .lo_match_pulse, .hi_overflow_pulse, .lo_overflow_pulse,
    .hi_overflow_irq, .lo_overflow_irq, .hi_toggle_pin, .lo_toggle_pin
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk1(input logic exp, input logic got);
    chk({7'h00, exp}, {7'h00, got});
  endtask

  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clock);
    #1;
    reg_wr_en = 1'b0;
  endtask

  // Read data is registered, so it is taken after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1;
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask

  // Pulses are combinational; sample them a few ns into the tick cycle
  task automatic tick_on(input int k);
    @(posedge clock);
    #1;
    prescale_tick = dtc_ticks_t'(4'h1 << k);
    #5;
  endtask

  task automatic tick_off();
    @(posedge clock);
    #1;
    prescale_tick = '0;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    stop_test();
  end

  initial
  begin
    {reg_addr, reg_wr_en, reg_rd_en, reg_wdata} = '0;
    prescale_tick = '0;
    {hi_counter, lo_counter, hi_compare, lo_compare} = {8'h10, 8'h10, 8'h20, 8'h20};
    mismatches = 0;
    num_checks = 0;
    do_reset();
    rd(DTC_STAT_ADDR, v);
    chk(DTC_STAT_RESET, v);
    chk(8'h00, {4'h0, hi_toggle_pin, lo_toggle_pin, hi_overflow_irq, lo_overflow_irq});
    rd(DTC_CTRL_ADDR, v);
    chk(DTC_CTRL_READBACK, v);
    rd(16'hFFB8, v);
    chk(DTC_UNMAPPED_READ, v);
    // Software must not be able to raise any flag
    wr(DTC_STAT_ADDR, 8'hFF);
    rd(DTC_STAT_ADDR, v);
    chk(8'h33, v);
    for (int c = 0; c < 8; c++)
    begin
      wr(DTC_CTRL_ADDR, {1'b0, 3'(c), 1'b0, 3'(c)});
      chk1(c == 0, cascade_mode);
      for (int k = 0; k < 4; k++)
      begin
        tick_on(k);
        chk1(c >= 4 && 7 - c == k, lo_count_tick);
        chk1(c >= 4 && 7 - c == k, hi_count_tick);
        tick_off();
      end
    end
    do_reset();
    wr(DTC_CTRL_ADDR, 8'h08);
    chk1(1'b1, lo_toggle_pin);
    wr(DTC_CTRL_ADDR, 8'h44);
    chk1(1'b0, lo_toggle_pin);
    lo_counter = 8'hFF;
    tick_on(3);
    chk1(1'b1, lo_overflow_pulse);
    chk1(1'b0, hi_overflow_pulse);
    tick_off();
    lo_counter = 8'h00;
    rd(DTC_STAT_ADDR, v);
    chk(8'h08, v);
    chk1(1'b0, lo_overflow_irq);
    wr(DTC_STAT_ADDR, 8'h0A);
    chk1(1'b1, lo_overflow_irq);
    // The previous write forgot the read, so this zero must not clear
    wr(DTC_STAT_ADDR, 8'h02);
    rd(DTC_STAT_ADDR, v);
    chk(8'h0A, v);
    wr(DTC_STAT_ADDR, 8'h02);
    rd(DTC_STAT_ADDR, v);
    chk(8'h02, v);
    chk1(1'b0, lo_overflow_irq);
    lo_counter = 8'hFF;
    tick_on(3);
    tick_off();
    rd(DTC_STAT_ADDR, v);
    // Clear and a new overflow land on the same edge
    @(posedge clock);
    #1;
    {reg_addr, reg_wdata, reg_wr_en} = {DTC_STAT_ADDR, 8'h02, 1'b1};
    prescale_tick = dtc_ticks_t'(4'h8);
    @(posedge clock);
    #1;
    {reg_wr_en, prescale_tick} = '0;
    rd(DTC_STAT_ADDR, v);
    chk(8'h0A, v);
    do_reset();
    wr(DTC_CTRL_ADDR, 8'h44);
    {lo_counter, lo_compare} = {8'h20, 8'h20};
    wr(DTC_STAT_ADDR, 8'h01);
    chk1(1'b0, lo_match_pulse);
    tick_on(3);
    chk1(1'b1, lo_match_pulse);
    chk1(1'b1, lo_clear_req);
    tick_off();
    chk1(1'b1, lo_toggle_pin);
    rd(DTC_STAT_ADDR, v);
    chk(8'h05, v);
    wr(DTC_STAT_ADDR, 8'h00);
    rd(DTC_STAT_ADDR, v);
    chk(8'h00, v);
    tick_on(3);
    chk1(1'b0, lo_clear_req);
    tick_off();
    chk1(1'b0, lo_toggle_pin);
    wr(DTC_CTRL_ADDR, 8'h50);
    hi_counter = 8'hFF;
    tick_on(2);
    chk1(1'b1, hi_overflow_pulse);
    tick_off();
    {hi_counter, hi_compare} = {8'h30, 8'h30};
    wr(DTC_STAT_ADDR, 8'h30);
    chk1(1'b1, hi_overflow_irq);
    tick_on(2);
    chk1(1'b1, hi_match_pulse);
    chk1(1'b1, hi_clear_req);
    tick_off();
    chk1(1'b1, hi_toggle_pin);
    wr(DTC_STAT_ADDR, 8'h30);
    rd(DTC_STAT_ADDR, v);
    chk(8'hF4, v);
    wr(DTC_STAT_ADDR, 8'h00);
    rd(DTC_STAT_ADDR, v);
    chk(8'h00, v);
    chk1(1'b0, hi_overflow_irq);
    do_reset();
    wr(DTC_CTRL_ADDR, 8'h06);
    {hi_counter, lo_counter, hi_compare, lo_compare} = {8'hFF, 8'hFF, 8'h12, 8'h34};
    tick_on(1);
    chk1(1'b1, hi_count_tick);
    chk1(1'b1, hi_overflow_pulse);
    tick_off();
    rd(DTC_STAT_ADDR, v);
    chk(8'h88, v);
    {hi_counter, lo_counter} = {8'h12, 8'h34};
    wr(DTC_STAT_ADDR, 8'h10);
    tick_on(1);
    chk1(1'b1, hi_match_pulse);
    chk1(1'b0, lo_match_pulse);
    chk1(1'b1, hi_clear_req);
    chk1(1'b1, lo_clear_req);
    tick_off();
    stop_test();
  end
endmodule
`default_nettype wire
